/* File: include/rcpk_pkg.sv */
// package of constants and types for the raw colour 12-bit packer
package rcpk_pkg;
  localparam int PIX_W = 12;
  localparam int BYTE_W = 8;
  localparam int COL_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int HI_MSB = 11;
  localparam int HI_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam logic [PIX_W-1:0] PIX_MIN = 12'h000;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;
  localparam logic [COL_W-1:0] COL_ZERO = 16'h0000;
  localparam logic [COL_W-1:0] COL_ONE = 16'h0001;
  localparam logic [1:0] PIX_PAIR_LEN = 2'h2;

  // colour of a sample at a given row parity and column parity
  typedef enum logic [1:0] {
    RCPK_BLUE  = 2'b00,
    RCPK_GREEN = 2'b01,
    RCPK_RED   = 2'b10
  } rcpk_color_t;

  // byte phase within one three-byte group
  typedef enum logic [1:0] {
    RCPK_IDLE  = 2'b00,
    RCPK_BYTE1 = 2'b01,
    RCPK_BYTE2 = 2'b10
  } rcpk_state_t;
endpackage : rcpk_pkg

/* File: rtl/rcpk_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module rcpk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // read data is taken combinationally from the memory at the head slot, not registered
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule : rcpk_fifo
`default_nettype wire

/* File: rtl/rcpk_packer.sv */
// packer of raw colour-mosaic 12-bit pixels into a three-bytes-per-pair stream
`timescale 1ns/10ps
`default_nettype none
// Function
// - In packed mode every pixel contributes exactly twelve bits to the stream.
// - Each consecutive pixel pair of a row becomes three consecutive bytes with no padding.
// - Samples are packed as received, with no interpolation or processing.
// - The first byte of a group holds bits 11..4 of the even pixel.
// - The second byte holds odd pixel bits 3..0 high and even pixel bits 3..0 low.
// - The third byte holds bits 11..4 of the odd pixel.
// - Even rows carry blue at even columns and green at odd columns, blue first.
// - Odd rows carry green at even columns and red at odd columns, green first.
// - Pixel values are unsigned twelve-bit numbers from 0x000 to 0xfff.
// - Bytes of a row leave in ascending order from the first pair to the last.
module rcpk_packer
  import rcpk_pkg::*;
(
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  input  wire logic                          RAW_COLOR_12BIT_PACKED_MODE,
  input  wire logic [rcpk_pkg::COL_W-1:0]    ROW_WIDTH,
  input  wire logic                          ROW_START,
  input  wire logic                          ROW_ODD,
  input  wire logic                          PIX_VALID,
  output logic                               PIX_READY,
  input  wire logic [rcpk_pkg::PIX_W-1:0]    PIX_DATA,
  output logic                               CONFIG_ERROR,
  output logic      [1:0]                    PIX_COLOR,
  output logic                               BYTE_VALID,
  input  wire logic                          BYTE_READY,
  output logic      [rcpk_pkg::BYTE_W-1:0]   BYTE_DATA,
  output logic                               ROW_DONE
);
  import rcpk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // colour of a sample from row and column parity
  function automatic rcpk_color_t color_of(input logic row_odd, input logic col_odd);
    if (!row_odd) begin
      color_of = col_odd ? RCPK_GREEN : RCPK_BLUE;
    end else begin
      color_of = col_odd ? RCPK_RED : RCPK_GREEN;
    end
  endfunction : color_of

  ////////////////////////////////////////////////////////////////////////////
  rcpk_state_t           state;
  logic [PIX_W-1:0]      even_pix;
  logic [PIX_W-1:0]      odd_pix;
  logic                  pair_ready;
  logic                  last_group;
  logic [COL_W-1:0]      col;
  logic [COL_W-1:0]      width;
  logic                  row_odd;
  logic                  active;
  logic                  width_ok;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic [BYTE_W-1:0]     fifo_in_data;
  logic                  pix_take;
  logic                  last_pix;
  logic                  accept;

  assign width_ok = !ROW_WIDTH[0] && (ROW_WIDTH != COL_ZERO);
  assign accept   = ROW_START && RAW_COLOR_12BIT_PACKED_MODE && width_ok;
  // a new pixel is taken only while no group is being emitted
  assign PIX_READY = active && (state == RCPK_IDLE) && !pair_ready;
  assign pix_take  = active && PIX_VALID && (state == RCPK_IDLE);
  assign last_pix  = (col == width - COL_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // row bookkeeping
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      active  <= 1'b0;
      width   <= COL_ZERO;
      row_odd <= 1'b0;
      col     <= COL_ZERO;
    end else if (accept && !active) begin
      active  <= 1'b1;
      width   <= ROW_WIDTH;
      row_odd <= ROW_ODD;
      col     <= COL_ZERO;
    end else if (pix_take && PIX_READY) begin
      col <= col + COL_ONE;
      if (last_pix) begin
        active <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CONFIG_ERROR <= 1'b0;
    end else if (ROW_START) begin
      CONFIG_ERROR <= !width_ok;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PIX_COLOR <= RCPK_BLUE;
    end else if (pix_take && PIX_READY) begin
      PIX_COLOR <= color_of(row_odd, col[0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel capture: samples are held verbatim, twelve bits each
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      even_pix  <= PIX_MIN;
      odd_pix   <= PIX_MIN;
    end else if (pix_take && PIX_READY) begin
      if (!col[0]) begin
        even_pix  <= PIX_DATA;
      end else begin
        odd_pix   <= PIX_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // group emission: three bytes per pair, stalled by fifo back-pressure
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= RCPK_IDLE;
    end else begin
      case (state)
        RCPK_IDLE: begin
          if (pair_ready && fifo_in_ready) begin
            state <= RCPK_BYTE1;
          end
        end
        RCPK_BYTE1: begin
          if (fifo_in_ready) begin
            state <= RCPK_BYTE2;
          end
        end
        RCPK_BYTE2: begin
          if (fifo_in_ready) begin
            state <= RCPK_IDLE;
          end
        end
        default: begin
          state <= RCPK_IDLE;
        end
      endcase
    end
  end

  // a pair is complete once the odd pixel has been taken
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pair_ready <= 1'b0;
    end else if (pix_take && PIX_READY && col[0]) begin
      pair_ready <= 1'b1;
    end else if (state == RCPK_IDLE && fifo_in_ready) begin
      pair_ready <= 1'b0;
    end
  end

  // marks the group of the row's last pair, so a next row may start while it drains
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      last_group <= 1'b0;
    end else if (pix_take && PIX_READY && last_pix) begin
      last_group <= 1'b1;
    end else if (state == RCPK_BYTE2 && fifo_in_ready) begin
      last_group <= 1'b0;
    end
  end

  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = '0;
    case (state)
      RCPK_IDLE: begin
        fifo_in_valid = pair_ready;
        fifo_in_data  = even_pix[HI_MSB:HI_LSB];
      end
      RCPK_BYTE1: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {odd_pix[LO_MSB:LO_LSB], even_pix[LO_MSB:LO_LSB]};
      end
      RCPK_BYTE2: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = odd_pix[HI_MSB:HI_LSB];
      end
      default: begin
        fifo_in_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ROW_DONE <= 1'b0;
    end else begin
      ROW_DONE <= (state == RCPK_BYTE2) && fifo_in_ready && last_group;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rcpk_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (BYTE_VALID),
    .out_ready (BYTE_READY),
    .out_data  (BYTE_DATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  chk_group_order: assert property (@(posedge CLOCK) disable iff (RST)
    (state == RCPK_BYTE1 && fifo_in_ready) |=> state == RCPK_BYTE2)
    else $error("second byte not followed by third");
  chk_first_byte: assert property (@(posedge CLOCK) disable iff (RST)
    (state == RCPK_IDLE && fifo_in_valid) |-> fifo_in_data == even_pix[HI_MSB:HI_LSB])
    else $error("first byte wrong");
  chk_mid_byte: assert property (@(posedge CLOCK) disable iff (RST)
    state == RCPK_BYTE1 |-> fifo_in_data[LO_MSB:LO_LSB] == even_pix[LO_MSB:LO_LSB]
      && fifo_in_data[BYTE_W-1:LO_MSB+1] == odd_pix[LO_MSB:LO_LSB])
    else $error("middle byte nibbles wrong");
  chk_last_byte: assert property (@(posedge CLOCK) disable iff (RST)
    state == RCPK_BYTE2 |-> fifo_in_data == odd_pix[HI_MSB:HI_LSB])
    else $error("third byte wrong");
  chk_pixel_kept: assert property (@(posedge CLOCK) disable iff (RST)
    (pix_take && PIX_READY && !col[0]) |=> even_pix == $past(PIX_DATA))
    else $error("sample altered");
  chk_color_even: assert property (@(posedge CLOCK) disable iff (RST)
    (pix_take && PIX_READY && !row_odd) |=> PIX_COLOR == (col[0] ? RCPK_BLUE : RCPK_GREEN))
    else $error("even row colour wrong");
  chk_color_odd: assert property (@(posedge CLOCK) disable iff (RST)
    (pix_take && PIX_READY && row_odd && !col[0]) |=> PIX_COLOR == RCPK_GREEN)
    else $error("odd row colour wrong");
  chk_odd_width: assert property (@(posedge CLOCK) disable iff (RST)
    (ROW_START && ROW_WIDTH[0]) |=> CONFIG_ERROR && !active || $past(active))
    else $error("odd width accepted");
  chk_col_step: assert property (@(posedge CLOCK) disable iff (RST)
    (pix_take && PIX_READY && !last_pix) |=> col == $past(col) + COL_ONE)
    else $error("column not ascending");

  cov_row_even: cover property (@(posedge CLOCK) accept && !ROW_ODD);
  cov_row_odd: cover property (@(posedge CLOCK) accept && ROW_ODD);
  cov_stall: cover property (@(posedge CLOCK) BYTE_VALID && !BYTE_READY && !fifo_in_ready);
  cov_row_done: cover property (@(posedge CLOCK) ROW_DONE);
endmodule : rcpk_packer
`default_nettype wire

/* File: dv/rcpk_host_sink.sv */
// host image buffer model: takes bytes, may stall or throttle at random
`timescale 1ns/10ps
`default_nettype none
module rcpk_host_sink (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic slow,
  output logic      byte_ready
);
  // ready changes only just after a rising edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_ready <= 1'b0;
    end else begin
      byte_ready <= !stall && (!slow || $urandom_range(1, 0) == 1);
    end
  end
endmodule : rcpk_host_sink
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench of the raw colour packer against a queue model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rcpk_pkg::*;
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             mode = 1'b1;
  logic [COL_W-1:0] row_width = COL_ZERO;
  logic             row_start = 1'b0;
  logic             row_odd = 1'b0;
  logic             pix_valid = 1'b0;
  logic [PIX_W-1:0] pix_data = PIX_MIN;
  logic             pix_ready, config_error, byte_valid, byte_ready, row_done;
  logic [1:0]       pix_color;
  logic [7:0]       byte_data;
  logic             stall = 1'b0;
  logic             slow = 1'b0;
  int               n_errors = 0;
  int               samples_checked = 0;
  int               rows_done = 0;
  int               cycles = 0;
  int               col = 0;
  logic             col_pend = 1'b0;
  logic [1:0]       col_exp;
  logic [PIX_W-1:0] even_pix;
  logic [7:0]       exp_q[$];

  always #25 clock = ~clock;

  rcpk_packer uut (.CLOCK(clock), .RST(rst), .RAW_COLOR_12BIT_PACKED_MODE(mode),
    .ROW_WIDTH(row_width), .ROW_START(row_start), .ROW_ODD(row_odd),
    .PIX_VALID(pix_valid), .PIX_READY(pix_ready), .PIX_DATA(pix_data),
    .CONFIG_ERROR(config_error), .PIX_COLOR(pix_color), .BYTE_VALID(byte_valid),
    .BYTE_READY(byte_ready), .BYTE_DATA(byte_data), .ROW_DONE(row_done));

  rcpk_host_sink sink (.clock(clock), .rst(rst), .stall(stall), .slow(slow),
    .byte_ready(byte_ready));

  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  // model: colour of each taken pixel, three bytes per completed pair
  always @(posedge clock) begin
    cycles++;
    if (col_pend) check(pix_color, col_exp);
    col_pend = pix_valid && pix_ready;
    if (col_pend) begin
      col_exp = row_odd ? (col[0] ? RCPK_RED : RCPK_GREEN) : (col[0] ? RCPK_GREEN : RCPK_BLUE);
      if (col[0]) begin
        exp_q.push_back(even_pix[HI_MSB:HI_LSB]);
        exp_q.push_back({pix_data[LO_MSB:LO_LSB], even_pix[LO_MSB:LO_LSB]});
        exp_q.push_back(pix_data[HI_MSB:HI_LSB]);
      end
      even_pix = pix_data;
      col++;
    end
    if (byte_valid && byte_ready) begin
      // a byte with nothing expected can never match the 16-bit marker
      if (exp_q.size() == 0) check(byte_data, 16'hffff);
      else check(byte_data, exp_q.pop_front());
    end
    if (row_done) rows_done++;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////
  // kind 0 random samples, kind 1 alternating pairs of zero and pairs of full scale
  task automatic run_row(input logic odd, input int w, input int kind);
    int t;
    int r0;
    @(posedge clock);
    r0 = rows_done;
    col = 0;
    row_start <= 1'b1;
    row_width <= w[COL_W-1:0];
    row_odd <= odd;
    @(posedge clock);
    row_start <= 1'b0;
    for (int i = 0; i < w; i++) begin
      pix_valid <= 1'b1;
      pix_data <= (kind == 1) ? (i[1] ? PIX_MAX : PIX_MIN) : 12'($urandom);
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (!pix_ready && t < 500);
    end
    pix_valid <= 1'b0;
    t = 0;
    while (rows_done == r0 && t < 3000) begin
      @(posedge clock);
      t++;
    end
    // the host may still be draining the buffer when the row is done
    t = 0;
    while (exp_q.size() != 0 && t < 3000) begin
      @(posedge clock);
      t++;
    end
    check(16'(rows_done - r0), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
  endtask : run_row

  task automatic bad_start(input logic m, input int w, input logic err);
    int r0;
    @(posedge clock);
    r0 = rows_done;
    mode <= m;
    row_start <= 1'b1;
    row_width <= w[COL_W-1:0];
    @(posedge clock);
    row_start <= 1'b0;
    repeat (4) @(posedge clock);
    check(config_error, err);
    check(pix_ready, 1'b0);
    check(16'(rows_done - r0), 16'h0000);
    mode <= 1'b1;
  endtask : bad_start

  ////////////////////////////////////////
  initial begin
    int seed;
    int r0;
    seed = $urandom(32'hb40cc42e);
    repeat (10) @(posedge clock);
    check({pix_ready, byte_valid, row_done, config_error, pix_color}, 16'h0000);
    rst <= 1'b0;
    run_row(1'b0, 2, 1);
    run_row(1'b1, 4, 1);
    bad_start(1'b1, 3, 1'b1);
    bad_start(1'b1, 0, 1'b1);
    bad_start(1'b0, 4, 1'b0);
    run_row(1'b1, 6, 0);
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      run_row(1'($urandom_range(1, 0)), 2 * $urandom_range(10, 1), 0);
    end
    // full buffer refuses more bytes while the host stalls
    slow <= 1'b0;
    stall <= 1'b1;
    r0 = rows_done;
    fork
      run_row(1'b0, 8, 0);
      begin
        repeat (80) @(posedge clock);
        check(byte_valid, 1'b1);
        check(pix_ready, 1'b0);
        check(16'(rows_done - r0), 16'h0000);
        stall <= 1'b0;
      end
    join
    run_row(1'b1, 2, 1);
    close_out();
  end
endmodule : tb
`default_nettype wire
